// ==== design/iwsc_defines.svh ====
// Constants for the idle wake-up source control link and its two ends.
`ifndef IWSC_DEFINES_SVH
`define IWSC_DEFINES_SVH
// =====================================================================
// Command framing
`define IWSC_CMD_IDLE 8'h07
`define IWSC_CMD_RDREG 8'h08
`define IWSC_IDLE_LEN 5'h10
`define IWSC_RDREG_LEN 5'h02
`define IWSC_POS_SOURCE 5'h02
`define IWSC_POS_WAKEUP_PERIOD 5'h03
`define IWSC_POS_SLEEP_PERIOD_COUNT 5'h04
`define IWSC_POS_REGSEL 5'h01
`define IWSC_REG_SOURCE 8'h00
`define IWSC_REG_EVENT 8'h01
// =====================================================================
// Reset values
`define IWSC_SOURCE_RESET 8'h08
`define IWSC_EVENT_RESET 8'h00
`define IWSC_WAKEUP_PERIOD_RESET 8'h00
`define IWSC_SLEEP_PERIOD_COUNT_RESET 5'h01
// =====================================================================
// Timing
`define IWSC_CLK_SYS_KHZ 100000
`define IWSC_SLOW_OSC_KHZ 32
`define IWSC_TICK_LAST 8'hFF
`define IWSC_SPC_MIN 5'h01
`define IWSC_SPC_MAX 5'h1E
`define IWSC_IRQ_PULSE_CYCLES 4'h6
`endif

// ==== design/iwsc_pkg.sv ====
// Types shared by the idle wake-up source control link and its two ends.
package iwsc_pkg;
   typedef logic [7:0] iwsc_byte_t;
   typedef struct packed {
      logic [1:0] slow_oscillator_rate;
      logic reserved_bit;
      logic select_wake;
      logic irq_wake;
      logic field_wake;
      logic tag_wake;
      logic timeout_wake;
   } iwsc_wake_t;
   typedef enum {IWSC_DEV_READY, IWSC_DEV_SLEEP} iwsc_dev_state_t;
   typedef enum {IWSC_HOST_IDLE, IWSC_HOST_SEND, IWSC_HOST_WAIT} iwsc_host_state_t;
endpackage : iwsc_pkg

// ==== design/iwsc_link_if.sv ====
// Link between the host controller and the wake-up control end of the transceiver.
`timescale 1ns/1ps
interface iwsc_link_if;
   logic cmd_valid;
   logic [7:0] cmd_byte;
   logic select_n;
   logic irq_in_n;
   logic rsp_valid;
   logic [7:0] rsp_byte;
   modport device (
      input cmd_valid,
      input cmd_byte,
      input select_n,
      input irq_in_n,
      output rsp_valid,
      output rsp_byte
   );
   modport host (
      output cmd_valid,
      output cmd_byte,
      output select_n,
      output irq_in_n,
      input rsp_valid,
      input rsp_byte
   );
endinterface : iwsc_link_if

// ==== design/iwsc_device.sv ====
// Transceiver end: idle command intake, wake-up source register, sleep and wake-up event record.
//
// Functional notes
// - Wake source is third idle command byte.
// - Source register holds oscillator rate and enables.
// - Event register updated on leaving wait_for_event.
// - Event register readable and sent on wake.
// - Bits 7:6 pick 32/16/8/4 kHz.
// - Bit 4: wake on select pin low.
// - Bit 3: wake on interrupt input low.
// - Host should set bit 3 always.
// - Bit 2: wake on RF field detected.
// - Bit 1: wake on tag detected.
// - Host sets bit 1 for tag detection.
// - Bit 0: wake after predefined timeout.
// - Timeout is (count+1)(period+2) 256-period ticks.
// - Host keeps sleep count within 01..1E.
// - Host sets bit 0 for timer, calibration.
`timescale 1ns/1ps
`include "iwsc_defines.svh"
module iwsc_device #(
   parameter int OSC_BASE_CYCLES = `IWSC_CLK_SYS_KHZ / `IWSC_SLOW_OSC_KHZ
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   iwsc_link_if.device link,
   input wire logic field_detect,
   input wire logic tag_detect,
   output iwsc_pkg::iwsc_wake_t wakeup_source_select,
   output iwsc_pkg::iwsc_wake_t wakeup_event_record,
   output logic in_wait_for_event
);
   import iwsc_pkg::*;

   // =====================================================================
   // Pin synchronisers
   logic [3:0] pin_raw;
   logic [3:0] pin_level;
   assign pin_raw = {link.select_n, link.irq_in_n, field_detect, tag_detect};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         logic [2:0] stage;
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               // Start from the idle level of each pin; pin_level still resets to the opposite level until the first enabled clock.
               stage <= (gi >= 2) ? 3'h7 : 3'h0;
            end else if (clk_en) begin
               stage <= {stage[1:0], pin_raw[gi]};
            end
         end
         // A change counts only once the two later stages agree.
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               pin_level[gi] <= (gi >= 2) ? 1'b0 : 1'b1;
            end else if (clk_en && (stage[1] == stage[2])) begin
               pin_level[gi] <= stage[2];
            end
         end
      end
   endgenerate

   logic select_low;
   logic irq_low;
   logic field_seen;
   logic tag_seen;
   assign select_low = ~pin_level[3];
   assign irq_low = ~pin_level[2];
   assign field_seen = pin_level[1];
   assign tag_seen = pin_level[0];

   // =====================================================================
   // Command intake
   iwsc_dev_state_t state;
   logic [4:0] byte_idx;
   iwsc_byte_t cur_cmd;
   logic [7:0] wakeup_period;
   logic [4:0] sleep_period_count;
   logic frame_last;
   logic idle_done;
   logic read_done;
   logic wake;

   assign frame_last = (cur_cmd == `IWSC_CMD_IDLE) ? (byte_idx == `IWSC_IDLE_LEN - 5'h01)
                                                   : (byte_idx == `IWSC_RDREG_LEN - 5'h01);
   assign idle_done = link.cmd_valid && (state == IWSC_DEV_READY) && (byte_idx != 5'h00)
                      && frame_last && (cur_cmd == `IWSC_CMD_IDLE);
   assign read_done = link.cmd_valid && (state == IWSC_DEV_READY) && (byte_idx != 5'h00)
                      && frame_last && (cur_cmd == `IWSC_CMD_RDREG);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         byte_idx <= 5'h00;
         cur_cmd <= 8'h00;
      end else if (clk_en && link.cmd_valid && (state == IWSC_DEV_READY)) begin
         if (byte_idx == 5'h00) begin
            // Unknown command codes are dropped and the intake stays at the first byte.
            if ((link.cmd_byte == `IWSC_CMD_IDLE) || (link.cmd_byte == `IWSC_CMD_RDREG)) begin
               cur_cmd <= link.cmd_byte;
               byte_idx <= 5'h01;
            end
         end else if (frame_last) begin
            byte_idx <= 5'h00;
         end else begin
            byte_idx <= byte_idx + 5'h01;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wakeup_source_select <= `IWSC_SOURCE_RESET;
         wakeup_period <= `IWSC_WAKEUP_PERIOD_RESET;
         sleep_period_count <= `IWSC_SLEEP_PERIOD_COUNT_RESET;
      end else if (clk_en && link.cmd_valid && (state == IWSC_DEV_READY) && (cur_cmd == `IWSC_CMD_IDLE)
                   && (byte_idx != 5'h00)) begin
         if (byte_idx == `IWSC_POS_SOURCE) begin
            wakeup_source_select <= link.cmd_byte;
         end else if (byte_idx == `IWSC_POS_WAKEUP_PERIOD) begin
            wakeup_period <= link.cmd_byte;
         end else if (byte_idx == `IWSC_POS_SLEEP_PERIOD_COUNT) begin
            sleep_period_count <= link.cmd_byte[4:0];
         end
      end
   end

   // =====================================================================
   // Sleep state
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state <= IWSC_DEV_READY;
         in_wait_for_event <= 1'b0;
      end else if (clk_en) begin
         case (state)
            IWSC_DEV_READY: begin
               if (idle_done) begin
                  state <= IWSC_DEV_SLEEP;
                  in_wait_for_event <= 1'b1;
               end
            end
            IWSC_DEV_SLEEP: begin
               if (wake) begin
                  state <= IWSC_DEV_READY;
                  in_wait_for_event <= 1'b0;
               end
            end
            default: begin
               state <= IWSC_DEV_READY;
               in_wait_for_event <= 1'b0;
            end
         endcase
      end
   end

   // The select line is still low from the idle frame itself, so a pin wake is only armed
   // once that pin has been seen high during the sleep; otherwise the device would wake at once.
   logic select_armed;
   logic irq_armed;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         select_armed <= 1'b0;
         irq_armed <= 1'b0;
      end else if (clk_en) begin
         if (state != IWSC_DEV_SLEEP) begin
            select_armed <= 1'b0;
            irq_armed <= 1'b0;
         end else begin
            select_armed <= select_armed | ~select_low;
            irq_armed <= irq_armed | ~irq_low;
         end
      end
   end

   // =====================================================================
   // Slow oscillator and timeout
   logic [15:0] div_cnt;
   logic [15:0] div_last;
   logic [7:0] per_cnt;
   logic [15:0] tick_cnt;
   logic [15:0] tick_target;
   logic ref_tick;

   assign div_last = 16'(OSC_BASE_CYCLES << wakeup_source_select.slow_oscillator_rate) - 16'h0001;
   assign ref_tick = (div_cnt == div_last) && (per_cnt == `IWSC_TICK_LAST);
   assign tick_target = ({11'h000, sleep_period_count} + 16'h0001) * ({8'h00, wakeup_period} + 16'h0002);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         div_cnt <= 16'h0000;
         per_cnt <= 8'h00;
         tick_cnt <= 16'h0000;
      end else if (clk_en) begin
         if (state != IWSC_DEV_SLEEP) begin
            div_cnt <= 16'h0000;
            per_cnt <= 8'h00;
            tick_cnt <= 16'h0000;
         end else if (div_cnt == div_last) begin
            div_cnt <= 16'h0000;
            per_cnt <= per_cnt + 8'h01;
            if (per_cnt == `IWSC_TICK_LAST) begin
               tick_cnt <= tick_cnt + 16'h0001;
            end
         end else begin
            div_cnt <= div_cnt + 16'h0001;
         end
      end
   end

   // =====================================================================
   // Wake decision
   logic [4:0] hit;
   logic [4:0] cause;
   assign hit[4] = wakeup_source_select.select_wake & select_armed & select_low;
   assign hit[3] = wakeup_source_select.irq_wake & irq_armed & irq_low;
   assign hit[2] = wakeup_source_select.field_wake & field_seen;
   assign hit[1] = wakeup_source_select.tag_wake & tag_seen;
   assign hit[0] = wakeup_source_select.timeout_wake & ref_tick & (tick_cnt == tick_target - 16'h0001);
   assign wake = (state == IWSC_DEV_SLEEP) && (hit != 5'h00);

   always_comb begin
      cause = 5'h00;
      if (hit[4]) begin
         cause = 5'h10;
      end else if (hit[3]) begin
         cause = 5'h08;
      end else if (hit[2]) begin
         cause = 5'h04;
      end else if (hit[1]) begin
         cause = 5'h02;
      end else if (hit[0]) begin
         cause = 5'h01;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wakeup_event_record <= `IWSC_EVENT_RESET;
      end else if (clk_en && wake) begin
         wakeup_event_record <= {wakeup_source_select.slow_oscillator_rate, 1'b0, cause};
      end
   end

   // =====================================================================
   // Replies
   // event byte on wake, selected register (source, event or 00) on read
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         link.rsp_valid <= 1'b0;
         link.rsp_byte <= 8'h00;
      end else if (clk_en) begin
         link.rsp_valid <= wake | read_done;
         if (wake) begin
            link.rsp_byte <= {wakeup_source_select.slow_oscillator_rate, 1'b0, cause};
         end else if (read_done) begin
            if (link.cmd_byte == `IWSC_REG_SOURCE) begin
               link.rsp_byte <= wakeup_source_select;
            end else if (link.cmd_byte == `IWSC_REG_EVENT) begin
               link.rsp_byte <= wakeup_event_record;
            end else begin
               link.rsp_byte <= 8'h00;
            end
         end
      end
   end

endmodule : iwsc_device

// ==== design/iwsc_host.sv ====
// Host end: builds idle and register read commands and drives the wake-up pins.
`timescale 1ns/1ps
`include "iwsc_defines.svh"
module iwsc_host (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   iwsc_link_if.host link,
   input wire logic start_idle,
   input wire iwsc_pkg::iwsc_wake_t wake_source,
   input wire logic [7:0] wakeup_period,
   input wire logic [4:0] sleep_period_count,
   input wire logic tag_calibrate,
   input wire logic start_read,
   input wire logic [7:0] read_sel,
   input wire logic wake_request,
   output logic busy,
   output logic result_valid,
   output logic [7:0] result_byte
);
   import iwsc_pkg::*;

   iwsc_host_state_t state;
   logic [4:0] idx;
   logic [4:0] len;
   iwsc_byte_t code;
   iwsc_byte_t src_byte;
   iwsc_byte_t wup_byte;
   iwsc_byte_t spc_byte;
   iwsc_byte_t sel_byte;
   iwsc_byte_t out_byte;
   logic [4:0] spc_clamped;
   iwsc_wake_t src_fixed;

   // =====================================================================
   // Parameter shaping
   // clamp sleep count
   assign spc_clamped = (sleep_period_count < `IWSC_SPC_MIN) ? `IWSC_SPC_MIN
                      : (sleep_period_count > `IWSC_SPC_MAX) ? `IWSC_SPC_MAX : sleep_period_count;
   always_comb begin
      src_fixed = wake_source;
      src_fixed.reserved_bit = 1'b0;
      src_fixed.irq_wake = 1'b1;
      src_fixed.tag_wake = wake_source.tag_wake | tag_calibrate;
      src_fixed.timeout_wake = wake_source.timeout_wake | tag_calibrate;
   end

   always_comb begin
      out_byte = 8'h00;
      if (idx == 5'h00) begin
         out_byte = code;
      end else if (code == `IWSC_CMD_RDREG) begin
         out_byte = sel_byte;
      end else if (idx == `IWSC_POS_SOURCE) begin
         out_byte = src_byte;
      end else if (idx == `IWSC_POS_WAKEUP_PERIOD) begin
         out_byte = wup_byte;
      end else if (idx == `IWSC_POS_SLEEP_PERIOD_COUNT) begin
         out_byte = spc_byte;
      end
   end

   // =====================================================================
   // Command sequencer
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state <= IWSC_HOST_IDLE;
         idx <= 5'h00;
         len <= 5'h00;
         code <= 8'h00;
         src_byte <= 8'h00;
         wup_byte <= 8'h00;
         spc_byte <= 8'h00;
         sel_byte <= 8'h00;
         busy <= 1'b0;
         link.cmd_valid <= 1'b0;
         link.cmd_byte <= 8'h00;
         link.select_n <= 1'b1;
         result_valid <= 1'b0;
         result_byte <= 8'h00;
      end else if (clk_en) begin
         link.cmd_valid <= 1'b0;
         result_valid <= 1'b0;
         case (state)
            IWSC_HOST_IDLE: begin
               idx <= 5'h00;
               if (start_idle) begin
                  code <= `IWSC_CMD_IDLE;
                  len <= `IWSC_IDLE_LEN;
                  src_byte <= src_fixed;
                  wup_byte <= wakeup_period;
                  spc_byte <= {3'h0, spc_clamped};
                  state <= IWSC_HOST_SEND;
                  busy <= 1'b1;
                  link.select_n <= 1'b0;
               end else if (start_read) begin
                  code <= `IWSC_CMD_RDREG;
                  len <= `IWSC_RDREG_LEN;
                  sel_byte <= read_sel;
                  state <= IWSC_HOST_SEND;
                  busy <= 1'b1;
                  link.select_n <= 1'b0;
               end
            end
            IWSC_HOST_SEND: begin
               link.cmd_valid <= 1'b1;
               link.cmd_byte <= out_byte;
               idx <= idx + 5'h01;
               if (idx == len - 5'h01) begin
                  state <= IWSC_HOST_WAIT;
                  link.select_n <= 1'b1;
               end
            end
            IWSC_HOST_WAIT: begin
               if (wake_request) begin
                  link.select_n <= 1'b0;
               end
               if (link.rsp_valid) begin
                  result_valid <= 1'b1;
                  result_byte <= link.rsp_byte;
                  busy <= 1'b0;
                  state <= IWSC_HOST_IDLE;
                  link.select_n <= 1'b1;
               end
            end
            default: begin
               state <= IWSC_HOST_IDLE;
            end
         endcase
      end
   end

   // =====================================================================
   // Wake pulse on the interrupt input
   // The pulse outlasts the far end's three-stage filter so that a sleeping device sees it.
   logic [3:0] irq_cnt;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irq_cnt <= 4'h0;
         link.irq_in_n <= 1'b1;
      end else if (clk_en) begin
         if (wake_request && (irq_cnt == 4'h0)) begin
            irq_cnt <= `IWSC_IRQ_PULSE_CYCLES;
            link.irq_in_n <= 1'b0;
         end else if (irq_cnt != 4'h0) begin
            irq_cnt <= irq_cnt - 4'h1;
            link.irq_in_n <= (irq_cnt == 4'h1);
         end
      end
   end

endmodule : iwsc_host

// ==== bench/iwsc_link_sva.sv ====
// Concurrent checks on the link between the host end and the wake-up control end.
`timescale 1ns/1ps
module iwsc_link_sva (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_byte,
   input wire logic select_n,
   input wire logic irq_in_n,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_byte
);
   // =====================================================================
   // Frame tracking
   // The byte position is rebuilt from the command code, because the select line alone does not mark each byte.
   logic [4:0] pos;
   logic [4:0] next_pos;
   logic [7:0] first;
   logic [7:0] src;
   logic [7:0] evt;
   always_comb begin
      if (pos == 5'h00)
         next_pos = (cmd_byte == 8'h07 || cmd_byte == 8'h08) ? 5'h01 : 5'h00;
      else if ((first == 8'h07 && pos == 5'h0F) || (first == 8'h08 && pos == 5'h01))
         next_pos = 5'h00;
      else
         next_pos = pos + 5'h01;
   end
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pos <= 5'h00;
         first <= 8'h00;
      end else if (cmd_valid) begin
         pos <= next_pos;
         if (pos == 5'h00)
            first <= cmd_byte;
      end
   end
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         src <= 8'h08;
         evt <= 8'h00;
      end else begin
         if (cmd_valid && pos == 5'h02 && first == 8'h07)
            src <= cmd_byte;
         if (rsp_valid && first == 8'h07)
            evt <= rsp_byte;
      end
   end
   // =====================================================================
   // Assertions
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   sequence s_read_last;
      cmd_valid && pos == 5'h01 && first == 8'h08;
   endsequence
   sequence s_wake_reply;
      rsp_valid && first == 8'h07;
   endsequence
   chk_idle_source_byte: assert property (cmd_valid && pos == 5'h02 && first == 8'h07 |-> cmd_byte[3] && !cmd_byte[5])
      else $error("idle source byte malformed");
   chk_idle_pad_zero: assert property (cmd_valid && first == 8'h07 && pos > 5'h04 |-> cmd_byte == 8'h00)
      else $error("idle frame padding not zero");
   chk_read_reply: assert property (s_read_last |=> rsp_valid && rsp_byte ==
      ($past(cmd_byte) == 8'h00 ? src : ($past(cmd_byte) == 8'h01 ? evt : 8'h00)))
      else $error("register read reply wrong");
   chk_event_one_flag: assert property (s_wake_reply |-> $onehot(rsp_byte[4:0]) && !rsp_byte[5])
      else $error("wake reply flags not one cause");
   chk_event_rate: assert property (s_wake_reply |-> rsp_byte[7:6] == src[7:6])
      else $error("wake reply rate differs");
   chk_event_enabled: assert property (s_wake_reply |-> (rsp_byte[4:0] & ~src[4:0]) == 5'h00)
      else $error("wake by disabled source");
   chk_reply_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("reply strobe too long");
   chk_reply_hold: assert property (!rsp_valid |-> $stable(rsp_byte))
      else $error("reply byte changed without strobe");
   chk_irq_pulse_len: assert property ($fell(irq_in_n) |-> !irq_in_n [*6] ##1 irq_in_n)
      else $error("interrupt pulse length wrong");
   chk_select_frame: assert property (cmd_valid && next_pos != 5'h00 |-> !select_n)
      else $error("select high inside a frame");
endmodule : iwsc_link_sva

// ==== bench/test_idle_wakeup_source_control.sv ====
// Self-checking bench for both ends of the idle wake-up source control link.
`timescale 1ns/1ps
module test_idle_wakeup_source_control;
   import iwsc_pkg::*;
   typedef struct {
      logic [2:0] act;
      logic [7:0] src;
      logic [7:0] per;
      logic [4:0] cnt;
      logic cal;
      logic [7:0] xsrc;
      logic [7:0] xevt;
      int cyc;
   } iwsc_row_t;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic field_detect = 1'b0;
   logic tag_detect = 1'b0;
   logic start_idle = 1'b0;
   logic start_read = 1'b0;
   logic tag_calibrate = 1'b0;
   logic wake_request = 1'b0;
   logic [7:0] wakeup_period = 8'h00;
   logic [4:0] sleep_period_count = 5'h01;
   logic [7:0] read_sel = 8'h00;
   iwsc_wake_t wake_source = 8'h00;
   logic busy;
   logic result_valid;
   logic [7:0] result_byte;
   iwsc_wake_t wakeup_source_select;
   iwsc_wake_t wakeup_event_record;
   logic in_wait_for_event;
   int failures = 0;
   int n_tests = 0;
   int cyc;
   logic [7:0] r;
   iwsc_row_t rows [13];
   always #5 clk_sys = ~clk_sys;
   iwsc_link_if link ();
   iwsc_device #(.OSC_BASE_CYCLES(2)) i_iwsc_device (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .link(link),
      .field_detect(field_detect), .tag_detect(tag_detect), .wakeup_source_select(wakeup_source_select),
      .wakeup_event_record(wakeup_event_record), .in_wait_for_event(in_wait_for_event));
   iwsc_host i_iwsc_host (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .link(link), .start_idle(start_idle),
      .wake_source(wake_source), .wakeup_period(wakeup_period), .sleep_period_count(sleep_period_count),
      .tag_calibrate(tag_calibrate), .start_read(start_read), .read_sel(read_sel), .wake_request(wake_request),
      .busy(busy), .result_valid(result_valid), .result_byte(result_byte));
   iwsc_link_sva i_iwsc_link_sva (.clk_sys(clk_sys), .reset(reset), .cmd_valid(link.cmd_valid),
      .cmd_byte(link.cmd_byte), .select_n(link.select_n), .irq_in_n(link.irq_in_n), .rsp_valid(link.rsp_valid),
      .rsp_byte(link.rsp_byte));
   // =====================================================================
   // Tasks
   task automatic stop_test;
      if (failures == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask : check8
   task automatic check1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : check1
   task automatic wait_res(input int lim);
      int k;
      k = 0;
      while (result_valid !== 1'b1 && k < lim) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      check1(result_valid, 1'b1);
      r = result_byte;
   endtask : wait_res
   task automatic do_read(input logic [7:0] sel, input logic [7:0] exp);
      @(negedge clk_sys);
      while (busy !== 1'b0)
         @(negedge clk_sys);
      read_sel = sel;
      start_read = 1'b1;
      @(negedge clk_sys);
      start_read = 1'b0;
      wait_res(100);
      check8(r, exp);
   endtask : do_read
   task automatic enter_idle(input iwsc_row_t w);
      @(negedge clk_sys);
      while (busy !== 1'b0)
         @(negedge clk_sys);
      wake_source = w.src;
      wakeup_period = w.per;
      sleep_period_count = w.cnt;
      tag_calibrate = w.cal;
      start_idle = 1'b1;
      @(negedge clk_sys);
      start_idle = 1'b0;
      cyc = 0;
      while (in_wait_for_event !== 1'b1 && cyc < 100) begin
         @(negedge clk_sys);
         cyc++;
      end
      check1(in_wait_for_event, 1'b1);
   endtask : enter_idle
   // Pins are released after each wake so that the next sleep starts from quiet inputs.
   task automatic run_idle(input iwsc_row_t w);
      enter_idle(w);
      cyc = 0;
      while (in_wait_for_event === 1'b1 && cyc < 40000) begin
         @(negedge clk_sys);
         cyc++;
         wake_request = (cyc == 10) ? w.act[2] : 1'b0;
         if (cyc == 10) begin
            field_detect = w.act[1];
            tag_detect = w.act[0];
         end
      end
      wait_res(20);
      @(negedge clk_sys);
      field_detect = 1'b0;
      tag_detect = 1'b0;
   endtask : run_idle
   task automatic check_reset;
      check8(wakeup_source_select, 8'h08);
      check8(wakeup_event_record, 8'h00);
      check1(in_wait_for_event, 1'b0);
      check1(busy, 1'b0);
   endtask : check_reset
   // =====================================================================
   // Sequence
   initial begin
      rows = '{'{3'h0, 8'h01, 8'h00, 5'h01, 1'b0, 8'h09, 8'h01, 2048},
         '{3'h0, 8'h41, 8'h01, 5'h01, 1'b0, 8'h49, 8'h41, 6144},
         '{3'h0, 8'h81, 8'h00, 5'h02, 1'b0, 8'h89, 8'h81, 12288},
         '{3'h0, 8'hC1, 8'h00, 5'h01, 1'b0, 8'hC9, 8'hC1, 16384},
         '{3'h0, 8'h21, 8'h00, 5'h00, 1'b0, 8'h09, 8'h01, 2048},
         '{3'h4, 8'h00, 8'h00, 5'h01, 1'b0, 8'h08, 8'h08, 0},
         '{3'h4, 8'h10, 8'h00, 5'h01, 1'b0, 8'h18, 8'h10, 0},
         '{3'h2, 8'h04, 8'h00, 5'h01, 1'b0, 8'h0C, 8'h04, 0},
         '{3'h1, 8'h02, 8'h00, 5'h01, 1'b0, 8'h0A, 8'h02, 0},
         '{3'h3, 8'h06, 8'h00, 5'h01, 1'b0, 8'h0E, 8'h04, 0},
         '{3'h3, 8'h01, 8'h00, 5'h01, 1'b0, 8'h09, 8'h01, 2048},
         '{3'h0, 8'h00, 8'h00, 5'h01, 1'b1, 8'h0B, 8'h01, 2048},
         '{3'h1, 8'h42, 8'h00, 5'h01, 1'b0, 8'h4A, 8'h42, 0}};
      repeat (4) @(negedge clk_sys);
      check_reset();
      reset = 1'b0;
      foreach (rows[i]) begin
         run_idle(rows[i]);
         check8(r, rows[i].xevt);
         if (rows[i].cyc != 0)
            check1(cyc >= rows[i].cyc - 2 && cyc <= rows[i].cyc + 8, 1'b1);
         check8(wakeup_source_select, rows[i].xsrc);
         check8(wakeup_event_record, rows[i].xevt);
         do_read(8'h00, rows[i].xsrc);
         do_read(8'h01, rows[i].xevt);
      end
      do_read(8'h02, 8'h00);
      do_read(8'h01, 8'h42);
      // A start given while the clock enable is low must not be taken.
      @(negedge clk_sys);
      clk_en = 1'b0;
      start_read = 1'b1;
      repeat (3) @(negedge clk_sys);
      check1(busy, 1'b0);
      check8(wakeup_event_record, 8'h42);
      start_read = 1'b0;
      clk_en = 1'b1;
      enter_idle('{3'h0, 8'h01, 8'hFF, 5'h1E, 1'b0, 8'h09, 8'h00, 0});
      reset = 1'b1;
      @(negedge clk_sys);
      check_reset();
      reset = 1'b0;
      @(posedge clk_sys);
      #1;
      check_reset();
      do_read(8'h00, 8'h08);
      stop_test();
   end
   initial begin
      #700000;
      failures++;
      stop_test();
   end
endmodule : test_idle_wakeup_source_control
